// >>> pssc_consts.svh
`ifndef PSSC_CONSTS_SVH
`define PSSC_CONSTS_SVH

`define PSSC_TS_PER_FRAME 32
`define PSSC_TS_BITS 5
`define PSSC_CODE_UNASSIGNED 4'h0
`define PSSC_CODE_ARB_EVEN_DN 4'hA
`define PSSC_CODE_DEC_EVEN_DN 4'h8
`define PSSC_CODE_EVEN_UP 4'h8
`define PSSC_CODE_ODD_DN_HIZ 4'hB
`define PSSC_CMD_WRITE_CM 4'h7
`define PSSC_ADDR_UP_BIT 7
`define PSSC_D_MSB 7
`define PSSC_D_LSB 6
`define PSSC_CI_MSB 5
`define PSSC_CI_LSB 2
`define PSSC_HS_IDLE 2'h3
`define PSSC_IDLE_BYTE 8'hFF
`define PSSC_FIFO_DEPTH 8
`define PSSC_FIFO_AW 3
`define PSSC_FRAME_TIME_US 125
`define PSSC_CLK_MHZ 25
`define PSSC_FRAME_CYCLES (`PSSC_FRAME_TIME_US * `PSSC_CLK_MHZ)

`endif

// >>> pssc_pkg.sv
`default_nettype none
package pssc_pkg;
  typedef enum logic [1:0] {
    PSSC_HUNT = 2'b00,
    PSSC_RUN = 2'b01,
    PSSC_LOST = 2'b11
  } pssc_sync_t;

  typedef enum logic [1:0] {
    PSSC_SCH_NONE = 2'b00,
    PSSC_SCH_ARB = 2'b01,
    PSSC_SCH_DEC = 2'b10
  } pssc_scheme_t;
endpackage
`default_nettype wire

// >>> pssc_change_fifo.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssc_consts.svh"
module pssc_change_fifo (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  input wire logic ovf_clr,
  output logic [7:0] head_data,
  output logic empty,
  output logic overflow
);
  logic [7:0] mem [0:`PSSC_FIFO_DEPTH-1];
  logic [`PSSC_FIFO_AW-1:0] wr_ptr_reg;
  logic [`PSSC_FIFO_AW-1:0] rd_ptr_reg;
  logic [`PSSC_FIFO_AW:0] count_reg;
  logic full;
  logic do_push;
  logic do_pop;

  assign full = (count_reg == (`PSSC_FIFO_AW+1)'(`PSSC_FIFO_DEPTH));
  assign do_pop = pop && (count_reg != '0);
  // a pop in the same cycle frees a slot, so a push into a full fifo with a
  // pop is still accepted
  assign do_push = push && (!full || do_pop);

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      case ({do_push, do_pop})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

  // outputs trail the pointers by one cycle so they come from flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      head_data <= 8'h00;
      empty <= 1'b1;
    end else begin
      head_data <= mem[rd_ptr_reg];
      empty <= (count_reg == '0);
    end
  end

  // a lost entry is sticky; a new loss beats a clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow <= 1'b0;
    end else if (push && full && !do_pop) begin
      overflow <= 1'b1;
    end else if (ovf_clr) begin
      overflow <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pssc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssc_consts.svh"
module pssc_top #(
  parameter int SYNC_LOSS_CYCLES = 2 * `PSSC_FRAME_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cm_reset,
  input wire logic [7:0] mp_data,
  input wire logic [7:0] mp_addr,
  input wire logic [7:0] mp_cmd,
  input wire logic mp_cmd_we,
  input wire logic handshake_en,
  input wire logic [4:0] mon_ts_sel,
  input wire logic [7:0] mon_tx_byte,
  input wire logic mon_mr_tx,
  input wire logic mon_mx_tx,
  input wire logic [2:0] arb_channel_sel,
  input wire logic [1:0] hdlc_d_tx,
  input wire logic arb_ci_en,
  input wire logic [3:0] arb_ci_value,
  input wire logic ci_fifo_pop,
  input wire logic cfi_dcl,
  input wire logic cfi_fsc,
  input wire logic cfi_du,
  output logic cfi_dd,
  output logic cfi_dd_oe,
  output logic [7:0] mon_rx_byte,
  output logic mon_rx_valid,
  output logic [1:0] mon_hs_rx,
  output logic [1:0] arb_d_bits,
  output logic [2:0] arb_d_channel,
  output logic arb_d_valid,
  output logic [7:0] ci_fifo_data,
  output logic ci_fifo_empty,
  output logic ci_fifo_overflow,
  output logic ci_irq,
  output logic sync_lost
);
  logic [3:0] code_dn [0:`PSSC_TS_PER_FRAME-1];
  logic [3:0] code_up [0:`PSSC_TS_PER_FRAME-1];
  logic [7:0] data_dn [0:`PSSC_TS_PER_FRAME-1];
  logic [7:0] data_up [0:`PSSC_TS_PER_FRAME-1];
  logic dcl_m, dcl_s, dcl_d, fsc_m, fsc_s, du_m, du_s;
  logic bit_en;
  logic [`PSSC_TS_BITS-1:0] ts_reg;
  logic [2:0] bit_reg;
  logic [`PSSC_TS_BITS-1:0] pos_ts;
  logic [2:0] pos_bit;
  logic [`PSSC_TS_BITS-1:0] even_ts;
  logic [`PSSC_TS_BITS-1:0] odd_ts;
  logic [2:0] chan;
  pssc_pkg::pssc_scheme_t sch_dn;
  pssc_pkg::pssc_sync_t sync_reg;
  logic [15:0] loss_cnt_reg;
  logic [7:0] tx_byte;
  logic [7:0] tx_oe;
  logic [6:0] rx_sh_reg;
  logic [7:0] rx_byte;
  logic byte_done;
  logic up_pair_on;
  logic ci_change;
  logic cm_wr;
  logic fifo_empty;

  // scheme of a pair follows from its even downstream code
  function automatic pssc_pkg::pssc_scheme_t scheme_of(input logic [3:0] c);
    if (c == `PSSC_CODE_ARB_EVEN_DN) begin
      scheme_of = pssc_pkg::PSSC_SCH_ARB;
    end else if (c == `PSSC_CODE_DEC_EVEN_DN) begin
      scheme_of = pssc_pkg::PSSC_SCH_DEC;
    end else begin
      scheme_of = pssc_pkg::PSSC_SCH_NONE;
    end
  endfunction

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dcl_m <= 1'b0;
      dcl_s <= 1'b0;
      dcl_d <= 1'b0;
      fsc_m <= 1'b0;
      fsc_s <= 1'b0;
      du_m <= 1'b1;
      du_s <= 1'b1;
    end else begin
      dcl_m <= cfi_dcl;
      dcl_s <= dcl_m;
      dcl_d <= dcl_s;
      fsc_m <= cfi_fsc;
      fsc_s <= fsc_m;
      du_m <= cfi_du;
      du_s <= du_m;
    end
  end

  assign bit_en = dcl_s && !dcl_d;

  // position of the bit handled at this bit clock; 5-bit slot count wraps
  always_comb begin
    pos_ts = ts_reg;
    pos_bit = bit_reg - 3'h1;
    if (fsc_s) begin
      pos_ts = '0;
      pos_bit = 3'h7;
    end else if (bit_reg == 3'h0) begin
      pos_ts = ts_reg + 5'h01;
    end
  end

  assign even_ts = {pos_ts[4:1], 1'b0};
  assign odd_ts = {pos_ts[4:1], 1'b1};
  assign chan = pos_ts[4:2];
  assign sch_dn = scheme_of(code_dn[even_ts]);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ts_reg <= 5'h1F;
      bit_reg <= 3'h0;
    end else if (bit_en) begin
      ts_reg <= pos_ts;
      bit_reg <= pos_bit;
    end
  end

  // missing frame pulses stop all preprocessing until the next one arrives
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= pssc_pkg::PSSC_HUNT;
      loss_cnt_reg <= 16'h0000;
    end else begin
      if (bit_en && fsc_s) begin
        loss_cnt_reg <= 16'h0000;
      end else if (loss_cnt_reg != 16'hFFFF) begin
        loss_cnt_reg <= loss_cnt_reg + 16'h0001;
      end
      case (sync_reg)
        pssc_pkg::PSSC_HUNT: begin
          if (bit_en && fsc_s) begin
            sync_reg <= pssc_pkg::PSSC_RUN;
          end
        end
        pssc_pkg::PSSC_RUN: begin
          if (loss_cnt_reg >= 16'(SYNC_LOSS_CYCLES)) begin
            sync_reg <= pssc_pkg::PSSC_LOST;
          end
        end
        default: begin
          if (bit_en && fsc_s) begin
            sync_reg <= pssc_pkg::PSSC_RUN;
          end
        end
      endcase
    end
  end

  // downstream byte of the current slot, built from control memory
  always_comb begin
    tx_byte = `PSSC_IDLE_BYTE;
    tx_oe = 8'h00;
    if (sync_reg == pssc_pkg::PSSC_RUN &&
        sch_dn != pssc_pkg::PSSC_SCH_NONE) begin
      tx_oe = 8'hFF;
      if (!pos_ts[0]) begin
        if (mon_ts_sel == even_ts) begin
          tx_byte = mon_tx_byte;
        end
      end else begin
        tx_byte[`PSSC_CI_MSB:`PSSC_CI_LSB] =
          data_dn[even_ts][`PSSC_CI_MSB:`PSSC_CI_LSB];
        if (sch_dn == pssc_pkg::PSSC_SCH_ARB && arb_ci_en &&
            chan == arb_channel_sel) begin
          tx_byte[`PSSC_CI_MSB:`PSSC_CI_LSB] = arb_ci_value;
        end
        if (handshake_en && mon_ts_sel == even_ts) begin
          tx_byte[1:0] = {mon_mr_tx, mon_mx_tx};
        end else begin
          tx_byte[1:0] = `PSSC_HS_IDLE;
        end
        if (sch_dn == pssc_pkg::PSSC_SCH_ARB &&
            chan == arb_channel_sel) begin
          tx_byte[`PSSC_D_MSB:`PSSC_D_LSB] = hdlc_d_tx;
        end else if (code_dn[odd_ts] == `PSSC_CODE_ODD_DN_HIZ ||
                     sch_dn == pssc_pkg::PSSC_SCH_DEC) begin
          tx_oe[`PSSC_D_MSB:`PSSC_D_LSB] = 2'b00;
        end else begin
          tx_oe[`PSSC_D_MSB:`PSSC_D_LSB] = 2'b00;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfi_dd <= 1'b1;
      cfi_dd_oe <= 1'b0;
    end else if (bit_en) begin
      cfi_dd <= tx_byte[pos_bit];
      cfi_dd_oe <= tx_oe[pos_bit];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sh_reg <= 7'h00;
    end else if (bit_en) begin
      rx_sh_reg <= {rx_sh_reg[5:0], du_s};
    end
  end

  assign rx_byte = {rx_sh_reg, du_s};
  assign byte_done = bit_en && pos_bit == 3'h0 &&
                     sync_reg == pssc_pkg::PSSC_RUN;
  assign up_pair_on = code_up[even_ts] == `PSSC_CODE_EVEN_UP;
  // reference compare against the previous frame's value
  assign ci_change = byte_done && pos_ts[0] && up_pair_on &&
    rx_byte[`PSSC_CI_MSB:`PSSC_CI_LSB] !=
    data_up[even_ts][`PSSC_CI_MSB:`PSSC_CI_LSB];
  assign cm_wr = mp_cmd_we && mp_cmd[7:4] == `PSSC_CMD_WRITE_CM;

  // codes; a reset of the memory beats a concurrent write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `PSSC_TS_PER_FRAME; i++) begin
        code_dn[i] <= `PSSC_CODE_UNASSIGNED;
        code_up[i] <= `PSSC_CODE_UNASSIGNED;
      end
    end else if (cm_reset) begin
      for (int i = 0; i < `PSSC_TS_PER_FRAME; i++) begin
        code_dn[i] <= `PSSC_CODE_UNASSIGNED;
        code_up[i] <= `PSSC_CODE_UNASSIGNED;
      end
    end else if (cm_wr) begin
      if (mp_addr[`PSSC_ADDR_UP_BIT]) begin
        code_up[mp_addr[4:0]] <= mp_cmd[3:0];
      end else begin
        code_dn[mp_addr[4:0]] <= mp_cmd[3:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (cm_wr && !mp_addr[`PSSC_ADDR_UP_BIT]) begin
      data_dn[mp_addr[4:0]] <= mp_data;
    end
  end

  // software write to the same slot wins over the hardware update
  always_ff @(posedge core_clk) begin
    if (cm_wr && mp_addr[`PSSC_ADDR_UP_BIT]) begin
      data_up[mp_addr[4:0]] <= mp_data;
    end
    if (ci_change && !(cm_wr && mp_addr[`PSSC_ADDR_UP_BIT] &&
                       mp_addr[4:0] == even_ts)) begin
      data_up[even_ts][`PSSC_CI_MSB:`PSSC_CI_LSB] <=
        rx_byte[`PSSC_CI_MSB:`PSSC_CI_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arb_d_bits <= 2'b11;
      arb_d_channel <= 3'h0;
      arb_d_valid <= 1'b0;
    end else begin
      arb_d_valid <= 1'b0;
      // decentral pairs never reach the arbiter
      if (byte_done && pos_ts[0] && up_pair_on &&
          sch_dn == pssc_pkg::PSSC_SCH_ARB) begin
        arb_d_bits <= rx_byte[`PSSC_D_MSB:`PSSC_D_LSB];
        arb_d_channel <= chan;
        arb_d_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_rx_byte <= 8'h00;
      mon_rx_valid <= 1'b0;
      mon_hs_rx <= `PSSC_HS_IDLE;
    end else begin
      mon_rx_valid <= 1'b0;
      if (byte_done && up_pair_on && mon_ts_sel == even_ts) begin
        if (!pos_ts[0]) begin
          mon_rx_byte <= rx_byte;
          mon_rx_valid <= 1'b1;
        end else begin
          mon_hs_rx <= rx_byte[1:0];
        end
      end
    end
  end

  pssc_change_fifo u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .push(ci_change),
    .push_data({1'b1, 2'b00, even_ts}),
    .pop(ci_fifo_pop),
    .ovf_clr(cm_reset),
    .head_data(ci_fifo_data),
    .empty(fifo_empty),
    .overflow(ci_fifo_overflow)
  );

  assign ci_fifo_empty = fifo_empty;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ci_irq <= 1'b0;
      sync_lost <= 1'b0;
    end else begin
      ci_irq <= !fifo_empty;
      sync_lost <= (sync_reg == pssc_pkg::PSSC_LOST);
    end
  end
endmodule
`default_nettype wire

// >>> pssc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pssc_top_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cm_reset,
  input wire logic [7:0] ci_fifo_data,
  input wire logic ci_fifo_empty,
  input wire logic ci_fifo_overflow,
  input wire logic ci_irq,
  input wire logic [1:0] arb_d_bits,
  input wire logic [2:0] arb_d_channel,
  input wire logic arb_d_valid,
  input wire logic [7:0] mon_rx_byte,
  input wire logic mon_rx_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_push;
    $fell(ci_fifo_empty);
  endsequence
  sequence s_arb_new;
    arb_d_valid || $past(arb_d_valid);
  endsequence
  sequence s_rx_new;
    mon_rx_valid || $past(mon_rx_valid);
  endsequence
  a_irq_level: assert property (ci_irq == !$past(ci_fifo_empty))
    else $error("irq does not follow fifo level");
  a_irq_on_push: assert property (s_push |=> ci_irq)
    else $error("no irq after change entry");
  a_entry_form: assert property (!ci_fifo_empty |->
    ci_fifo_data[7:5] == 3'b100 && !ci_fifo_data[0])
    else $error("change entry not an even upstream slot");
  a_ovf_sticky: assert property (ci_fifo_overflow && !cm_reset
    |=> ci_fifo_overflow)
    else $error("overflow flag dropped");
  a_ovf_full: assert property ($rose(ci_fifo_overflow) |-> !ci_fifo_empty)
    else $error("overflow with empty fifo");
  a_arb_upd: assert property (($changed(arb_d_bits) ||
    $changed(arb_d_channel)) |-> s_arb_new)
    else $error("arbiter bits changed without valid");
  a_arb_gap: assert property (arb_d_valid |=> !arb_d_valid [*8])
    else $error("arbiter valid too close");
  a_rx_upd: assert property ($changed(mon_rx_byte) |-> s_rx_new)
    else $error("monitor byte changed without valid");
  a_rx_gap: assert property (mon_rx_valid |=> !mon_rx_valid [*8])
    else $error("monitor valid too close");
endmodule
bind pssc_top pssc_top_checker u_chk (.core_clk, .reset_n, .cm_reset,
  .ci_fifo_data, .ci_fifo_empty, .ci_fifo_overflow, .ci_irq, .arb_d_bits,
  .arb_d_channel, .arb_d_valid, .mon_rx_byte, .mon_rx_valid);
`default_nettype wire

// >>> pssc_line_model.sv
`timescale 1ns/1ns
`default_nettype none
module pssc_line_model (
  input wire logic cfi_dd,
  input wire logic cfi_dd_oe,
  input wire logic [7:0] up_even,
  input wire logic [7:0] up_odd,
  output logic cfi_dcl,
  output logic cfi_fsc,
  output logic cfi_du,
  output logic [7:0] dn_even,
  output logic [7:0] dn_odd,
  output logic d_oe,
  output logic [8:0] oe_bits,
  output logic [7:0] frames
);
  logic [7:0] ev;
  logic [7:0] od;
  logic [8:0] cnt;
  logic doe;
  initial begin
    cfi_dcl = 1'b0;
    cfi_fsc = 1'b0;
    cfi_du = 1'b1;
    oe_bits = 9'h000;
    frames = 8'h00;
    forever begin
      cnt = 9'h000;
      doe = 1'b0;
      for (int s = 0; s < 32; s++) begin
        for (int b = 7; b >= 0; b--) begin
          cfi_fsc = (s == 0) && (b == 7);
          // pair sits on slots 2/3; idle slots read as the pulled-up level
          cfi_du = (s == 2) ? up_even[b] : (s == 3) ? up_odd[b] : 1'b1;
          #240;
          cfi_dcl = 1'b1;
          #239;
          // a released line floats to the pulled-up level
          if (s == 2) ev[b] = cfi_dd_oe ? cfi_dd : 1'b1;
          if (s == 3) od[b] = cfi_dd_oe ? cfi_dd : 1'b1;
          if (s == 3 && b == 7) doe = cfi_dd_oe;
          cnt = cnt + {8'h00, cfi_dd_oe};
          #1;
          cfi_dcl = 1'b0;
        end
      end
      dn_even = ev;
      dn_odd = od;
      d_oe = doe;
      oe_bits = cnt;
      frames = frames + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> pssc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pssc_top_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cm_reset = 1'b0;
  logic [7:0] mp_data = 8'h00;
  logic [7:0] mp_addr = 8'h00;
  logic [7:0] mp_cmd = 8'h00;
  logic mp_cmd_we = 1'b0;
  logic handshake_en = 1'b0;
  logic [4:0] mon_ts_sel = 5'h02;
  logic [7:0] mon_tx_byte = 8'h5A;
  logic mon_mr_tx = 1'b0;
  logic mon_mx_tx = 1'b1;
  logic [2:0] arb_channel_sel = 3'h0;
  logic [1:0] hdlc_d_tx = 2'h2;
  logic arb_ci_en = 1'b0;
  logic [3:0] arb_ci_value = 4'h9;
  logic ci_fifo_pop = 1'b0;
  logic [7:0] up_even = 8'h3C;
  logic [7:0] up_odd = 8'h7F;
  wire logic cfi_dcl, cfi_fsc, cfi_du, cfi_dd, cfi_dd_oe, d_oe;
  wire logic mon_rx_valid, arb_d_valid, ci_fifo_empty, ci_fifo_overflow;
  wire logic ci_irq, sync_lost;
  wire logic [7:0] mon_rx_byte, ci_fifo_data, dn_even, dn_odd, frames;
  wire logic [1:0] mon_hs_rx, arb_d_bits;
  wire logic [2:0] arb_d_channel;
  wire logic [8:0] oe_bits;
  int mismatches = 0;
  int samples_checked = 0;
  int rx_pulses = 0;
  int arb_pulses = 0;
  int mark = 0;
  always @(posedge core_clk) begin
    rx_pulses <= rx_pulses + int'(mon_rx_valid === 1'b1);
    arb_pulses <= arb_pulses + int'(arb_d_valid === 1'b1);
  end
  always #20 core_clk = ~core_clk;
  pssc_top #(.SYNC_LOSS_CYCLES(8000)) dut (.core_clk, .reset_n, .cm_reset,
    .mp_data, .mp_addr, .mp_cmd, .mp_cmd_we, .handshake_en, .mon_ts_sel,
    .mon_tx_byte, .mon_mr_tx, .mon_mx_tx, .arb_channel_sel, .hdlc_d_tx,
    .arb_ci_en, .arb_ci_value, .ci_fifo_pop, .cfi_dcl, .cfi_fsc, .cfi_du,
    .cfi_dd, .cfi_dd_oe, .mon_rx_byte, .mon_rx_valid, .mon_hs_rx,
    .arb_d_bits, .arb_d_channel, .arb_d_valid, .ci_fifo_data,
    .ci_fifo_empty, .ci_fifo_overflow, .ci_irq, .sync_lost);
  pssc_line_model line (.cfi_dd, .cfi_dd_oe, .up_even, .up_odd, .cfi_dcl,
    .cfi_fsc, .cfi_du, .dn_even, .dn_odd, .d_oe, .oe_bits, .frames);
  task chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    step(1);
    mp_addr = a;
    mp_data = d;
    mp_cmd = c;
    mp_cmd_we = 1'b1;
    step(1);
    mp_cmd_we = 1'b0;
  endtask
  // the line model runs on its own timing; realign to the core clock after
  task frm(input int n);
    logic [7:0] f;
    f = frames;
    wait (frames == f + 8'(n));
    step(1);
  endtask
  task summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #3600000;
    mismatches++;
    summarize();
  end
  initial begin
    step(4);
    reset_n = 1'b1;
    frm(2);
    chk(oe_bits, 9'h000);
    wr(8'h02, 8'hC3, 8'h78);
    wr(8'h03, 8'h00, 8'h7B);
    wr(8'h82, 8'hFF, 8'h78);
    wr(8'h83, 8'h00, 8'h70);
    wr(8'h04, 8'hC3, 8'h6A);
    frm(2);
    chk(oe_bits, 9'd14);
    chk({1'b0, dn_even}, 9'h05A);
    chk({3'h0, dn_odd[5:0]}, 9'h003);
    chk({8'h00, d_oe}, 9'h000);
    chk({7'h00, arb_d_bits}, 9'h003);
    chk({8'h00, ci_fifo_empty}, 9'h001);
    chk({1'b0, mon_rx_byte}, 9'h03C);
    chk(9'(rx_pulses), 9'd2);
    up_odd = 8'h56;
    frm(3);
    chk({8'h00, ci_fifo_empty}, 9'h000);
    chk({8'h00, ci_irq}, 9'h001);
    chk({1'b0, ci_fifo_data}, 9'h082);
    chk({7'h00, mon_hs_rx}, 9'h002);
    ci_fifo_pop = 1'b1;
    step(1);
    ci_fifo_pop = 1'b0;
    step(2);
    chk({8'h00, ci_fifo_empty}, 9'h001);
    frm(2);
    chk({8'h00, ci_irq}, 9'h000);
    handshake_en = 1'b1;
    mark = arb_pulses;
    wr(8'h02, 8'hC3, 8'h7A);
    frm(2);
    chk(oe_bits, 9'd16);
    chk({8'h00, d_oe}, 9'h001);
    chk({7'h00, dn_odd[7:6]}, 9'h002);
    chk({7'h00, dn_odd[1:0]}, 9'h001);
    chk({7'h00, arb_d_bits}, 9'h001);
    chk({6'h00, arb_d_channel}, 9'h000);
    chk(9'(arb_pulses - mark), 9'd2);
    arb_ci_en = 1'b1;
    frm(2);
    chk({5'h00, dn_odd[5:2]}, 9'h009);
    arb_channel_sel = 3'h1;
    frm(2);
    chk({8'h00, d_oe}, 9'h000);
    chk({5'h00, dn_odd[5:2]}, 9'h000);
    wr(8'h02, 8'hC3, 8'h78);
    // a zero reference on the idle pairs at slots 4 to 31 floods the change fifo in one frame
    for (int i = 4; i < 32; i += 2) begin
      wr(8'h80 | 8'(i), 8'h00, 8'h78);
    end
    frm(2);
    chk({8'h00, d_oe}, 9'h000);
    chk(oe_bits, 9'd14);
    chk({8'h00, ci_fifo_overflow}, 9'h001);
    chk({1'b0, ci_fifo_data}, 9'h084);
    chk({8'h00, sync_lost}, 9'h000);
    cm_reset = 1'b1;
    step(1);
    cm_reset = 1'b0;
    frm(2);
    chk(oe_bits, 9'h000);
    chk({8'h00, ci_fifo_overflow}, 9'h000);
    summarize();
  end
endmodule
`default_nettype wire
